//--- ecst_top.sv
// ecst_top: ecc data unit status and error address trap for the flash array.
// assumes: array read engine, program engine and bus front end share mclk;
// reset, clear and transaction strobes arrive as one-cycle pulses.
`timescale 1ns/100ps
module ecst_top (
	input wire logic mclk,
	input wire logic arst_n,
	// configuration and straps
	input wire logic doubleBitEnable,
	input wire logic trapTypeSelect,
	input wire ecst_pkg::ecst_dens_t density,
	// soft resets and the clear-status transaction
	input wire logic softReset,
	input wire logic csSignalReset,
	input wire logic clearStatus,
	// array read results, one pulse per data unit checked
	input wire logic arrayReadActive,
	input wire logic unitChecked,
	input wire logic [ecst_pkg::ADDR_W-1:0] unitAddr,
	input wire logic singleBitFixed,
	input wire logic doubleBitSeen,
	// program engine
	input wire logic unitProgrammed,
	input wire logic unitReprogram,
	input wire logic [ecst_pkg::ADDR_W-1:0] progAddr,
	input wire logic unitErase,
	input wire logic [ecst_pkg::ADDR_W-1:0] eraseAddr,
	// dedicated register read transaction
	input wire logic regReadReq,
	input wire ecst_pkg::ecst_sel_t regReadSel,
	input wire logic [ecst_pkg::ADDR_W-1:0] regReadAddr,
	input wire logic serialMode,
	output logic [ecst_pkg::WORD_W-1:0] regReadData,
	output logic regReadValid,
	output logic programError,
	output logic errorTrapped
);
	// per-unit flags: [2] two-bit seen, [1] one-bit fixed, [0] correction off
	logic [2:0] unitMem_r [ecst_pkg::UNIT_DEPTH];
	logic [2:0] unitMem_nxt [ecst_pkg::UNIT_DEPTH];

	ecst_pkg::ecst_rd_state_t rdState_r;
	ecst_pkg::ecst_rd_state_t rdState_nxt;
	ecst_pkg::ecst_sel_t sel_r;
	ecst_pkg::ecst_sel_t sel_nxt;
	logic serial_r;
	logic serial_nxt;
	logic [2:0] lookFlags_r;
	logic [2:0] lookFlags_nxt;
	// configuration held from the taking edge so a read answers one setting
	logic dblEn_r;
	logic dblEn_nxt;
	ecst_pkg::ecst_dens_t dens_r;
	ecst_pkg::ecst_dens_t dens_nxt;
	logic [ecst_pkg::WORD_W-1:0] regReadData_nxt;
	logic regReadValid_nxt;
	logic programError_nxt;
	logic errorTrapped_nxt;

	logic anyClear;
	logic unitOff;
	logic oneBitEvent;
	logic twoBitEvent;
	logic trapEvent;

	ecst_trap_if tif();
	ecst_resp_if rif();

	// index of the data unit that holds an address
	function automatic logic [ecst_pkg::UNIT_IDX_W-1:0] unitIdx(
		input logic [ecst_pkg::ADDR_W-1:0] a);
		unitIdx = a[ecst_pkg::UNIT_LSB +: ecst_pkg::UNIT_IDX_W];
	endfunction

	// status word of one unit as seen under the current configuration
	function automatic logic [ecst_pkg::WORD_W-1:0] statusOf(input logic [2:0] f,
		input logic dblEn);
		logic [ecst_pkg::WORD_W-1:0] w;
		w = ecst_pkg::STATUS_RESET;
		w[ecst_pkg::STAT_2BD_POS] = f[2] & dblEn;
		w[ecst_pkg::STAT_1BC_POS] = f[1];
		w[ecst_pkg::STAT_OFF_POS] = f[0] & ~dblEn;
		statusOf = w;
	endfunction

	// every soft reset and the clear transaction wipe the volatile results
	assign anyClear = softReset | csSignalReset | clearStatus;

	// qualify a checked unit: no error is recognised where correction is off
	always_comb begin
		unitOff = unitMem_r[unitIdx(unitAddr)][0] & ~doubleBitEnable;
		oneBitEvent = unitChecked & arrayReadActive & singleBitFixed & ~unitOff;
		twoBitEvent = unitChecked & arrayReadActive & doubleBitSeen & doubleBitEnable
			& ~unitOff;
		// select line picks two-bit only, or either kind
		trapEvent = twoBitEvent | (trapTypeSelect & oneBitEvent);
	end

	// trap helper: first qualified error since the last clear
	assign tif.capture = trapEvent;
	assign tif.clear = anyClear;
	assign tif.capAddr = unitAddr;

	ecst_trap u_trap (
		.mclk(mclk),
		.arst_n(arst_n),
		.tif(tif)
	);

	// per-unit flag store: read results, reprogramming and erase
	always_comb begin
		for (int i = 0; i < ecst_pkg::UNIT_DEPTH; i++) begin
			unitMem_nxt[i] = unitMem_r[i];
			if (anyClear) begin
				unitMem_nxt[i][2:1] = 2'h0;
			end
		end
		if (unitErase) begin
			unitMem_nxt[unitIdx(eraseAddr)] = ecst_pkg::UNIT_RESET;
		end
		if (unitProgrammed && unitReprogram && !doubleBitEnable) begin
			unitMem_nxt[unitIdx(progAddr)][0] = 1'b1;
		end
		// a result arriving with a clear is kept
		if (oneBitEvent) begin
			unitMem_nxt[unitIdx(unitAddr)][1] = 1'b1;
		end
		if (twoBitEvent) begin
			unitMem_nxt[unitIdx(unitAddr)][2] = 1'b1;
		end
	end

	// flag store registers
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < ecst_pkg::UNIT_DEPTH; i++) begin
				unitMem_r[i] <= ecst_pkg::UNIT_RESET;
			end
		end else begin
			for (int i = 0; i < ecst_pkg::UNIT_DEPTH; i++) begin
				unitMem_r[i] <= unitMem_nxt[i];
			end
		end
	end

	// program error for a second program into a unit with detection on
	always_comb begin
		programError_nxt = unitProgrammed & unitReprogram & doubleBitEnable;
		errorTrapped_nxt = tif.trapped;
	end

	// program error and trap flag outputs
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			programError <= 1'b0;
			errorTrapped <= 1'b0;
		end else begin
			programError <= programError_nxt;
			errorTrapped <= errorTrapped_nxt;
		end
	end

	// answer formatting helper
	assign rif.sel = sel_r;
	assign rif.serialMode = serial_r;
	assign rif.density = dens_r; // density as taken with the request
	assign rif.statusWord = statusOf(lookFlags_r, dblEn_r);
	assign rif.trapVal = tif.trapVal;

	ecst_resp u_resp (
		.rif(rif)
	);

	// read sequencer: take request, look up the unit, answer once
	always_comb begin
		rdState_nxt = rdState_r;
		sel_nxt = sel_r;
		serial_nxt = serial_r;
		lookFlags_nxt = lookFlags_r;
		dblEn_nxt = dblEn_r;
		dens_nxt = dens_r;
		regReadData_nxt = regReadData;
		regReadValid_nxt = 1'b0;
		case (rdState_r)
			ecst_pkg::RD_IDLE: begin
				if (regReadReq) begin
					sel_nxt = regReadSel;
					serial_nxt = serialMode;
					lookFlags_nxt = unitMem_r[unitIdx(regReadAddr)];
					dblEn_nxt = doubleBitEnable;
					dens_nxt = density;
					rdState_nxt = ecst_pkg::RD_LOOK;
				end
			end
			ecst_pkg::RD_LOOK: begin
				rdState_nxt = ecst_pkg::RD_ANSWER;
			end
			ecst_pkg::RD_ANSWER: begin
				regReadData_nxt = rif.answer;
				regReadValid_nxt = 1'b1;
				rdState_nxt = ecst_pkg::RD_IDLE;
			end
			default: begin
				rdState_nxt = ecst_pkg::RD_IDLE;
			end
		endcase
	end

	// read sequencer registers
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rdState_r <= ecst_pkg::RD_IDLE;
			sel_r <= ecst_pkg::SEL_STATUS;
			serial_r <= 1'b0;
			lookFlags_r <= ecst_pkg::UNIT_RESET;
			dblEn_r <= 1'b0;
			dens_r <= ecst_pkg::DENS_256;
			regReadData <= ecst_pkg::STATUS_RESET;
			regReadValid <= 1'b0;
		end else begin
			rdState_r <= rdState_nxt;
			sel_r <= sel_nxt;
			serial_r <= serial_nxt;
			lookFlags_r <= lookFlags_nxt;
			dblEn_r <= dblEn_nxt;
			dens_r <= dens_nxt;
			regReadData <= regReadData_nxt;
			regReadValid <= regReadValid_nxt;
		end
	end
endmodule

//--- ecst_pkg.sv
// ecst_pkg: constants and types for the ecc status and address trap block.
// assumes: included in compile order before every other file of the block.
package ecst_pkg;

	// widths of the words this block handles
	localparam int ADDR_W = 32;
	localparam int WORD_W = 16;
	localparam int SER_W = 8;

	// a data unit is an aligned 16-byte line; index bits into the status window
	localparam int UNIT_LSB = 4;
	localparam int UNIT_IDX_W = 6;
	localparam int UNIT_DEPTH = 64;

	// field positions inside ecc_unit_status
	localparam int STAT_OFF_POS = 0;
	localparam int STAT_1BC_POS = 1;
	localparam int STAT_2BD_POS = 3;

	// values after reset
	localparam logic [WORD_W-1:0] STATUS_RESET = 16'h0000;
	localparam logic [ADDR_W-1:0] TRAP_RESET = 32'h0000_0000;
	localparam logic [2:0] UNIT_RESET = 3'h0;

	// upper trap word: address bits from 16 up to the density's top bit
	localparam int ADDR_HI_LSB = 16;
	localparam logic [WORD_W-1:0] HI_MASK_256 = 16'h00FF;
	localparam logic [WORD_W-1:0] HI_MASK_512 = 16'h01FF;
	localparam logic [WORD_W-1:0] HI_MASK_1G = 16'h03FF;

	// which register a dedicated read transaction asks for
	typedef enum logic [1:0] {
		SEL_STATUS = 2'h0,
		SEL_TRAP_LO = 2'h1,
		SEL_TRAP_HI = 2'h2
	} ecst_sel_t;

	// device density strap
	typedef enum logic [1:0] {
		DENS_256 = 2'h0,
		DENS_512 = 2'h1,
		DENS_1G = 2'h2
	} ecst_dens_t;

	// register read sequencer states
	typedef enum logic [2:0] {
		RD_IDLE = 3'b001,
		RD_LOOK = 3'b010,
		RD_ANSWER = 3'b100
	} ecst_rd_state_t;

endpackage

//--- ecst_if.sv
// ecst_if: carriers between the top module and its trap and answer helpers.
// assumes: all parties run on the same interface clock.
`timescale 1ns/100ps

// trap capture request and trapped value
interface ecst_trap_if;
	logic capture;
	logic clear;
	logic [ecst_pkg::ADDR_W-1:0] capAddr;
	logic [ecst_pkg::ADDR_W-1:0] trapVal;
	logic trapped;
	modport trap (input capture, input clear, input capAddr, output trapVal, output trapped);
	modport user (output capture, output clear, output capAddr, input trapVal, input trapped);
endinterface

// answer formatting for dedicated read transactions
interface ecst_resp_if;
	ecst_pkg::ecst_sel_t sel;
	logic serialMode;
	ecst_pkg::ecst_dens_t density;
	logic [ecst_pkg::WORD_W-1:0] statusWord;
	logic [ecst_pkg::ADDR_W-1:0] trapVal;
	logic [ecst_pkg::WORD_W-1:0] answer;
	modport fmt (input sel, input serialMode, input density, input statusWord, input trapVal,
		output answer);
	modport user (output sel, output serialMode, output density, output statusWord,
		output trapVal, input answer);
endinterface

//--- ecst_trap.sv
// ecst_trap: holds the address of the first enabled ecc error since clear.
// assumes: capture is only raised for qualified array-read errors.
`timescale 1ns/100ps
module ecst_trap (
	input wire logic mclk,
	input wire logic arst_n,
	ecst_trap_if.trap tif
);
	logic trapped_r;
	logic trapped_nxt;
	logic [ecst_pkg::ADDR_W-1:0] addr_r;
	logic [ecst_pkg::ADDR_W-1:0] addr_nxt;

	// first error wins; a capture in the clearing cycle survives the clear
	always_comb begin
		trapped_nxt = trapped_r;
		addr_nxt = addr_r;
		if (tif.clear) begin
			trapped_nxt = 1'b0;
			addr_nxt = ecst_pkg::TRAP_RESET;
		end
		if (tif.capture && (!trapped_r || tif.clear)) begin
			trapped_nxt = 1'b1;
			addr_nxt = tif.capAddr;
		end
	end

	// trap storage
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			trapped_r <= 1'b0;
			addr_r <= ecst_pkg::TRAP_RESET;
		end else begin
			trapped_r <= trapped_nxt;
			addr_r <= addr_nxt;
		end
	end

	assign tif.trapVal = addr_r;
	assign tif.trapped = trapped_r;
endmodule

//--- ecst_resp.sv
// ecst_resp: builds the answer word for a dedicated register read.
// assumes: the caller registers the answer before it leaves the block.
`timescale 1ns/100ps
module ecst_resp (
	ecst_resp_if.fmt rif
);
	// density sets how many upper address bits are real
	function automatic logic [ecst_pkg::WORD_W-1:0] hiMask(input ecst_pkg::ecst_dens_t d);
		case (d)
			ecst_pkg::DENS_256: hiMask = ecst_pkg::HI_MASK_256;
			ecst_pkg::DENS_512: hiMask = ecst_pkg::HI_MASK_512;
			ecst_pkg::DENS_1G: hiMask = ecst_pkg::HI_MASK_1G;
			default: hiMask = ecst_pkg::HI_MASK_256;
		endcase
	endfunction

	// select and trim the answer
	always_comb begin
		case (rif.sel)
			ecst_pkg::SEL_STATUS: begin
				if (rif.serialMode) begin
					rif.answer = {8'h00, rif.statusWord[ecst_pkg::SER_W-1:0]};
				end else begin
					rif.answer = rif.statusWord;
				end
			end
			ecst_pkg::SEL_TRAP_LO: rif.answer = rif.trapVal[ecst_pkg::WORD_W-1:0];
			ecst_pkg::SEL_TRAP_HI: begin
				rif.answer = rif.trapVal[ecst_pkg::ADDR_HI_LSB +: ecst_pkg::WORD_W]
					& hiMask(rif.density);
			end
			default: rif.answer = ecst_pkg::STATUS_RESET;
		endcase
	end
endmodule

//--- ecst_top_sva.sv
// ecst_top_sva: port-level checks on ecst_top.
// assumes: bound to every ecst_top; one clock domain.
`timescale 1ns/100ps
module ecst_top_sva (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic doubleBitEnable,
	input wire ecst_pkg::ecst_dens_t density,
	input wire logic softReset,
	input wire logic csSignalReset,
	input wire logic clearStatus,
	input wire logic arrayReadActive,
	input wire logic unitChecked,
	input wire logic doubleBitSeen,
	input wire logic unitProgrammed,
	input wire logic unitReprogram,
	input wire logic regReadReq,
	input wire ecst_pkg::ecst_sel_t regReadSel,
	input wire logic serialMode,
	input wire logic [ecst_pkg::WORD_W-1:0] regReadData,
	input wire logic regReadValid,
	input wire logic programError,
	input wire logic errorTrapped
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	// status answers three cycles after the request
	sequence statAns;
		regReadValid && $past(regReadSel, 3) == ecst_pkg::SEL_STATUS;
	endsequence
	chk_read_lat: assert property (regReadValid |-> $past(regReadReq, 3))
		else $error("answer without request");
	chk_valid_once: assert property (regReadValid |=> !regReadValid)
		else $error("answer valid too long");
	chk_reserved_zero: assert property (statAns
		|-> regReadData[15:4] == 12'h000 && !regReadData[2])
		else $error("reserved status bits set");
	chk_serial_byte: assert property (statAns
		##0 $past(serialMode, 3) |-> regReadData[15:8] == 8'h00)
		else $error("serial status wider than a byte");
	chk_dbl_off: assert property (statAns
		##0 !$past(doubleBitEnable, 3) |-> !regReadData[3])
		else $error("two-bit flag with detection off");
	chk_hi_mask: assert property (regReadValid
		&& $past(regReadSel, 3) == ecst_pkg::SEL_TRAP_HI
		&& $past(density, 3) == ecst_pkg::DENS_256 |-> regReadData[15:8] == 8'h00)
		else $error("upper trap bits beyond density");
	chk_hi_mask_mid: assert property (regReadValid
		&& $past(regReadSel, 3) == ecst_pkg::SEL_TRAP_HI
		&& $past(density, 3) == ecst_pkg::DENS_512 |-> regReadData[15:9] == 7'h00)
		else $error("upper trap bits beyond mid density");
	chk_trap_set: assert property (arrayReadActive && unitChecked
		&& doubleBitSeen && doubleBitEnable
		##1 !(softReset || csSignalReset || clearStatus) |-> ##1 errorTrapped)
		else $error("two-bit error not trapped");
	chk_trap_cause: assert property ($rose(errorTrapped)
		|-> $past(arrayReadActive, 2) && $past(unitChecked, 2))
		else $error("trap outside array read");
	chk_trap_clear: assert property ((softReset || csSignalReset || clearStatus)
		&& !unitChecked |-> ##2 !errorTrapped)
		else $error("trap not cleared");
	chk_prog_err: assert property (unitProgrammed && unitReprogram
		&& doubleBitEnable |=> programError)
		else $error("reprogram without program error");
	chk_err_cause: assert property (programError
		|-> $past(unitReprogram) && $past(doubleBitEnable))
		else $error("spurious program error");
	cover property (errorTrapped && regReadValid);
	cover property (programError);
	cover property (regReadValid && serialMode);
endmodule
bind ecst_top ecst_top_sva chk (.mclk, .arst_n, .doubleBitEnable, .density, .softReset,
	.csSignalReset, .clearStatus, .arrayReadActive, .unitChecked, .doubleBitSeen,
	.unitProgrammed, .unitReprogram, .regReadReq, .regReadSel, .serialMode,
	.regReadData, .regReadValid, .programError, .errorTrapped);

//--- ecst_host.sv
// ecst_host: host controller model issuing dedicated register reads.
// assumes: the bench owns mclk and calls rd from one process.
`timescale 1ns/100ps
module ecst_host (
	input wire logic mclk,
	input wire logic regReadValid,
	input wire logic [15:0] regReadData,
	output logic regReadReq,
	output ecst_pkg::ecst_sel_t regReadSel,
	output logic [31:0] regReadAddr,
	output logic serialMode
);
	initial begin
		regReadReq = 1'b0;
		regReadSel = ecst_pkg::SEL_STATUS;
		regReadAddr = 32'h0000_0000;
		serialMode = 1'b0;
	end
	// one-cycle request, then a bounded wait for the answer pulse
	task automatic rd(input ecst_pkg::ecst_sel_t s, input logic [31:0] a, input logic ser,
		output logic [15:0] d, output logic ok);
		ok = 1'b0;
		d = 16'hFFFF;
		@(negedge mclk);
		regReadSel = s;
		regReadAddr = a;
		serialMode = ser;
		regReadReq = 1'b1;
		@(negedge mclk);
		regReadReq = 1'b0;
		regReadAddr = ~a; // address no longer valid
		repeat (6) begin
			@(negedge mclk);
			if (!ok && regReadValid === 1'b1) begin
				d = regReadData;
				ok = 1'b1;
			end
		end
	endtask
endmodule

//--- ecst_top_tb.sv
// ecst_top_tb: directed test of ecst_top through host reads and engine pulses.
// assumes: ecst_host and the bound checker are compiled before this file.
`timescale 1ns/100ps
module ecst_top_tb;
	logic mclk = 1'b0;
	logic arst_n = 1'b0;
	logic doubleBitEnable = 1'b0, trapTypeSelect = 1'b1, softReset = 1'b0, csSignalReset = 1'b0;
	logic clearStatus = 1'b0, arrayReadActive = 1'b1, unitChecked = 1'b0, singleBitFixed = 1'b0;
	logic doubleBitSeen = 1'b0, unitProgrammed = 1'b0, unitReprogram = 1'b0, unitErase = 1'b0;
	logic [31:0] unitAddr = 32'h0, progAddr = 32'h0, eraseAddr = 32'h0, regReadAddr;
	ecst_pkg::ecst_dens_t density = ecst_pkg::DENS_1G;
	ecst_pkg::ecst_sel_t regReadSel;
	logic regReadReq, serialMode, regReadValid, programError, errorTrapped;
	logic [15:0] regReadData;
	int errorCnt = 0, compares = 0, cycles = 0;
	always #10 mclk = ~mclk;
	ecst_top dut (.mclk, .arst_n, .doubleBitEnable, .trapTypeSelect, .density, .softReset,
		.csSignalReset, .clearStatus, .arrayReadActive, .unitChecked, .unitAddr, .singleBitFixed,
		.doubleBitSeen, .unitProgrammed, .unitReprogram, .progAddr, .unitErase, .eraseAddr,
		.regReadReq, .regReadSel, .regReadAddr, .serialMode, .regReadData, .regReadValid,
		.programError, .errorTrapped);
	ecst_host host (.mclk, .regReadValid, .regReadData, .regReadReq, .regReadSel, .regReadAddr,
		.serialMode);
	task automatic printVerdict();
		$display("compares %0d errors %0d", compares, errorCnt);
		if (errorCnt == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic cmpw(input string nm, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			errorCnt++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic cmpb(input string nm, input logic exp, input logic got);
		cmpw(nm, {15'h0, exp}, {15'h0, got});
	endtask
	// register read with expected answer
	task automatic rdc(input string nm, input ecst_pkg::ecst_sel_t s, input logic [31:0] a,
		input logic ser, input logic [15:0] exp);
		logic [15:0] d;
		logic ok;
		host.rd(s, a, ser, d, ok);
		cmpb("answered", 1'b1, ok);
		cmpw(nm, exp, d);
	endtask
	// n back-to-back checked units from address a
	task automatic ev(input logic [31:0] a, input logic s, input logic d, input int n);
		for (int i = 0; i < n; i++) begin
			@(negedge mclk);
			unitChecked = 1'b1;
			unitAddr = a + 32'(16 * i);
			singleBitFixed = s;
			doubleBitSeen = d;
		end
		@(negedge mclk);
		unitChecked = 1'b0;
		unitAddr = ~a;
		singleBitFixed = 1'b0;
		doubleBitSeen = 1'b0;
		@(negedge mclk);
	endtask
	// program or erase pulse, program error sampled in the following cycle
	task automatic pg(input logic [31:0] a, input logic er, input logic expErr);
		@(negedge mclk);
		progAddr = a;
		eraseAddr = a;
		unitProgrammed = !er;
		unitReprogram = 1'b1;
		unitErase = er;
		@(negedge mclk);
		unitProgrammed = 1'b0;
		unitErase = 1'b0;
		cmpb("programError", expErr, programError);
	endtask
	task automatic clr(input int k);
		@(negedge mclk);
		{softReset, csSignalReset, clearStatus} = 3'h1 << k;
		@(negedge mclk);
		{softReset, csSignalReset, clearStatus} = 3'h0;
		@(negedge mclk);
	endtask
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 3000) begin
			errorCnt++;
			printVerdict();
		end
	end
	initial begin
		repeat (8) @(negedge mclk);
		arst_n = 1'b1;
		rdc("status idle", ecst_pkg::SEL_STATUS, 32'h0, 1'b0, 16'h0000);
		pg(32'h10, 1'b0, 1'b0);
		rdc("status off", ecst_pkg::SEL_STATUS, 32'h10, 1'b0, 16'h0001);
		rdc("status other", ecst_pkg::SEL_STATUS, 32'h20, 1'b0, 16'h0000);
		ev(32'h10, 1'b1, 1'b0, 1);
		cmpb("trapped off unit", 1'b0, errorTrapped);
		arrayReadActive = 1'b0;
		ev(32'h50, 1'b1, 1'b1, 1);
		cmpb("trapped no read", 1'b0, errorTrapped);
		arrayReadActive = 1'b1;
		doubleBitEnable = 1'b1;
		trapTypeSelect = 1'b0;
		rdc("status off dbl", ecst_pkg::SEL_STATUS, 32'h10, 1'b0, 16'h0000);
		pg(32'h10, 1'b0, 1'b1);
		ev(32'h12345, 1'b1, 1'b0, 1);
		cmpb("trapped single", 1'b0, errorTrapped);
		rdc("status single", ecst_pkg::SEL_STATUS, 32'h12345, 1'b0, 16'h0002);
		ev(32'h0F23_4567, 1'b0, 1'b1, 2);
		cmpb("trapped double", 1'b1, errorTrapped);
		rdc("trap low", ecst_pkg::SEL_TRAP_LO, 32'h0, 1'b0, 16'h4567);
		rdc("trap high 1G", ecst_pkg::SEL_TRAP_HI, 32'h0, 1'b0, 16'h0323);
		density = ecst_pkg::DENS_512;
		rdc("trap high 512", ecst_pkg::SEL_TRAP_HI, 32'h0, 1'b0, 16'h0123);
		density = ecst_pkg::DENS_256;
		rdc("trap high 256", ecst_pkg::SEL_TRAP_HI, 32'h0, 1'b1, 16'h0023);
		rdc("status serial", ecst_pkg::SEL_STATUS, 32'h0F23_4567, 1'b1, 16'h0008);
		for (int k = 0; k < 3; k++) begin
			clr(k);
			cmpb("trapped cleared", 1'b0, errorTrapped);
			rdc("trap low cleared", ecst_pkg::SEL_TRAP_LO, 32'h0, 1'b0, 16'h0000);
			ev(32'h30, 1'b0, 1'b1, 1);
		end
		doubleBitEnable = 1'b0;
		rdc("status dbl off", ecst_pkg::SEL_STATUS, 32'h30, 1'b0, 16'h0000);
		pg(32'h10, 1'b1, 1'b0);
		rdc("status erased", ecst_pkg::SEL_STATUS, 32'h10, 1'b0, 16'h0000);
		// hardware reset in mid-run empties the trap
		@(negedge mclk);
		arst_n = 1'b0;
		@(negedge mclk);
		arst_n = 1'b1;
		cmpb("trapped after reset", 1'b0, errorTrapped);
		rdc("trap low reset", ecst_pkg::SEL_TRAP_LO, 32'h0, 1'b0, 16'h0000);
		// either kind selected: a one-bit error is trapped too
		trapTypeSelect = 1'b1;
		ev(32'h40, 1'b1, 1'b0, 1);
		cmpb("trapped one-bit", 1'b1, errorTrapped);
		rdc("trap low one-bit", ecst_pkg::SEL_TRAP_LO, 32'h0, 1'b0, 16'h0040);
		printVerdict();
	end
endmodule
